// ===== shared/vhp_pkg.sv
// Shared constants and types for the host port transfer master
package vhp_pkg;
  localparam int          BYTE_W     = 8;     // Bits carried per phase
  localparam int          PAIR_CYC   = 4;     // Link clocks per byte phase
  localparam logic [1:0]  CYC_LAST   = 2'h3;  // Last cycle index of a phase
  localparam logic [1:0]  CYC_READY  = 2'h1;  // Cycle where slave shows ready
  localparam logic [1:0]  CYC_STOP   = 2'h2;  // Cycle where slave shows stop
  localparam logic [1:0]  DEVSEL     = 2'h1;  // Device select field
  // Register space selectors (command low nibble, register access)
  localparam logic [3:0]  NIB_CFG    = 4'h0;
  localparam logic [3:0]  NIB_GEN    = 4'h1;
  localparam logic [3:0]  NIB_NLR1   = 4'h2;
  localparam logic [3:0]  NIB_NLR2   = 4'h3;
  // Channel selectors (command low nibble, channel access)
  localparam logic [3:0]  NIB_FST0   = 4'h0;
  localparam logic [3:0]  NIB_FST1   = 4'h1;
  localparam logic [3:0]  NIB_CHA    = 4'h4;
  localparam logic [3:0]  NIB_CHB    = 4'h5;
  localparam logic [3:0]  NIB_CHC    = 4'h6;
  localparam logic [1:0]  CHD_ABSENT = 2'h3;  // Status 1 low bits
  localparam logic [2:0]  WAIT_OK    = 3'h1;  // Waits per byte without risk
  // Answer codes
  localparam logic [1:0]  RSP_OK     = 2'h0;
  localparam logic [1:0]  RSP_STOP   = 2'h1;
  localparam logic [1:0]  RSP_BAD    = 2'h2;

  typedef enum logic [2:0] {
    L_IDLE, L_CMD, L_ADDR, L_DEC, L_RETRY, L_WAIT, L_DATA, L_TA
  } vhp_lstate_t;
endpackage

// ===== design/vhp_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module vhp_sync2 (
  input  wire logic clk,    // Destination clock
  input  wire logic rst_n,  // Synchronous reset, active low
  input  wire logic d,      // Level from the other domain
  output logic      q       // Synchronised level
);
  logic meta_q;
  logic sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule

// ===== design/vhp_pair_shift.sv
// Byte shifter that moves two bits per clock, upper pair first
`timescale 1ns/1ps
module vhp_pair_shift #(
  parameter int W = 8
) (
  input  wire logic         clk,    // Link clock
  input  wire logic         rst_n,  // Synchronous reset, active low
  input  wire logic         load,   // Load parallel value (wins over shift)
  input  wire logic [W-1:0] val,    // Parallel value
  input  wire logic         shift,  // Shift up by one pair
  input  wire logic [1:0]   sin,    // Pair entering at the bottom
  output logic      [W-1:0] q       // Register; top pair drives the lines
);
  logic [W-1:0] sh_q;
  logic [W-1:0] sh_d;

  // Elaboration check: the shift slices need at least two whole pairs
  if (W < 4 || (W % 2) != 0) begin : g_bad_w
    $error("vhp_pair_shift: W must be even and at least 4");
  end

  // Next value: load, shift or hold
  always_comb begin
    sh_d = sh_q;
    if (load) begin
      sh_d = val;
    end else if (shift) begin
      sh_d = {sh_q[W-3:0], sin};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end
  assign q = sh_q;
endmodule

// ===== design/vhp_host.sv
// Host port transfer master: request side on clk_sys, pins on link clock
// Functional notes
// - Each transfer opens with an 8-bit command byte on the two lines.
// - Register transfers send a low address byte; channel transfers skip it.
// - One decode clock follows the header phases.
// - No stop and no ready in retry leads to a wait phase.
// - No ready and no stop repeats a wait phase.
// - Bus owner keeps driving the lines during wait phases.
// - Ready seen in a retry or wait phase makes the next a data phase.
// - Data bytes travel over the two lines in data phases.
// - A read ends with one turnaround clock, lines released.
// - Master may start again right after the turnaround clock.
// - Master drives control to frame; slave drives it for ready and stop.
`timescale 1ns/1ps
module vhp_host
  import vhp_pkg::*;
(
  input  wire logic        clk_sys,              // System clock
  input  wire logic        rst_n,                // Synchronous reset, active low
  input  wire logic        req_valid,            // Transfer request
  output logic             req_ready,            // Request can be taken
  input  wire logic        req_read,             // 1 read, 0 write
  input  wire logic        req_chan,             // 1 channel, 0 register access
  input  wire logic [3:0]  req_space,            // Command low nibble
  input  wire logic [7:0]  req_addr,             // Low register address
  input  wire logic [7:0]  req_wdata,            // Write byte
  output logic             rsp_valid,            // One-cycle answer strobe
  output logic [1:0]       rsp_code,             // Ok, stopped or refused
  output logic [7:0]       rsp_rdata,            // Read byte
  output logic             rsp_slow,             // Extra waits were seen on a register access
  output logic             rsp_d_absent,         // Status 1 shows channel D absent
  input  wire logic        host_port_clock_pin,  // Link clock
  input  wire logic        host_ad_line_zero_i,  // Line zero level
  output logic             host_ad_line_zero_o,  // Line zero drive value
  output logic             host_ad_line_zero_oe, // Line zero driven
  input  wire logic        host_ad_line_one_i,   // Line one level
  output logic             host_ad_line_one_o,   // Line one drive value
  output logic             host_ad_line_one_oe,  // Line one driven
  input  wire logic        host_control_line_i,  // Control line level
  output logic             host_control_line_o,  // Control drive value
  output logic             host_control_line_oe  // Control driven
);
  // ---------------- System side ----------------
  logic       ready_q, ready_d, tgl_q, tgl_d, done_s, dprev_q;
  logic       h_read_q, h_read_d, h_chan_q, h_chan_d;
  logic [3:0] h_nib_q, h_nib_d;
  logic [7:0] h_addr_q, h_addr_d, h_wdata_q, h_wdata_d;
  logic       rv_q, rv_d, slow_q, slow_d, dabs_q, dabs_d;
  logic [1:0] rc_q, rc_d;
  logic [7:0] rd_q, rd_d;
  // Link side results, stable while the done toggle is in flight
  logic       res_slow_q;
  logic [1:0] res_code_q;
  logic [7:0] res_rdata_q;
  logic       done_tgl_q;

  // Only the documented command combinations are issued
  function automatic logic cmd_legal(input logic rd, input logic ch,
                                     input logic [3:0] nib);
    logic ok;
    ok = 1'b0;
    if (!ch) begin
      ok = (nib == NIB_CFG) || (nib == NIB_GEN) ||
           (rd && ((nib == NIB_NLR1) || (nib == NIB_NLR2)));
    end else if (rd) begin
      ok = (nib == NIB_FST0) || (nib == NIB_FST1) ||
           (nib == NIB_CHA) || (nib == NIB_CHC);
    end else begin
      ok = (nib == NIB_CHB);
    end
    return ok;
  endfunction

  vhp_sync2 u_done_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     (done_tgl_q),
    .q     (done_s)
  );

  // Request capture, refusal and answer collection
  always_comb begin
    ready_d   = ready_q;
    tgl_d     = tgl_q;
    h_read_d  = h_read_q;
    h_chan_d  = h_chan_q;
    h_nib_d   = h_nib_q;
    h_addr_d  = h_addr_q;
    h_wdata_d = h_wdata_q;
    rv_d      = 1'b0;
    rc_d      = rc_q;
    rd_d      = rd_q;
    slow_d    = slow_q;
    dabs_d    = dabs_q;
    if (req_valid && ready_q) begin
      if (cmd_legal(req_read, req_chan, req_space)) begin
        h_read_d  = req_read;
        h_chan_d  = req_chan;
        h_nib_d   = req_space;
        h_addr_d  = req_addr;
        h_wdata_d = req_wdata;
        ready_d   = 1'b0;
        tgl_d     = ~tgl_q;
      end else begin
        rv_d   = 1'b1;
        rc_d   = RSP_BAD;
        rd_d   = '0;
        slow_d = 1'b0;
        dabs_d = 1'b0;
      end
    end
    if (done_s != dprev_q) begin
      rv_d    = 1'b1;
      ready_d = 1'b1;
      rc_d    = res_code_q;
      rd_d    = res_rdata_q;
      slow_d  = res_slow_q;
      dabs_d  = h_chan_q && h_read_q && (h_nib_q == NIB_FST1) &&
                (res_rdata_q[1:0] == CHD_ABSENT) && (res_code_q == RSP_OK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_q   <= 1'b1;
      tgl_q     <= 1'b0;
      dprev_q   <= 1'b0;
      h_read_q  <= 1'b0;
      h_chan_q  <= 1'b0;
      h_nib_q   <= 4'h0;
      h_addr_q  <= 8'h00;
      h_wdata_q <= 8'h00;
      rv_q      <= 1'b0;
      rc_q      <= RSP_OK;
      rd_q      <= 8'h00;
      slow_q    <= 1'b0;
      dabs_q    <= 1'b0;
    end else begin
      ready_q   <= ready_d;
      tgl_q     <= tgl_d;
      dprev_q   <= done_s;
      h_read_q  <= h_read_d;
      h_chan_q  <= h_chan_d;
      h_nib_q   <= h_nib_d;
      h_addr_q  <= h_addr_d;
      h_wdata_q <= h_wdata_d;
      rv_q      <= rv_d;
      rc_q      <= rc_d;
      rd_q      <= rd_d;
      slow_q    <= slow_d;
      dabs_q    <= dabs_d;
    end
  end

  assign req_ready    = ready_q;
  assign rsp_valid    = rv_q;
  assign rsp_code     = rc_q;
  assign rsp_rdata    = rd_q;
  assign rsp_slow     = slow_q;
  assign rsp_d_absent = dabs_q;

  // ---------------- Link side ----------------
  logic        lrst_n, req_s, seen_q;
  vhp_lstate_t st_q, st_d;
  logic [1:0]  cyc_q, cyc_d;
  logic        rdy_q, rdy_d, stop_q, stop_d;
  logic [2:0]  waits_q, waits_d;
  logic        ad_oe_q, ad_oe_d, ctl_oe_q, ctl_oe_d, ctl_out_q, ctl_out_d;
  logic        done_d, res_slow_d, fin;
  logic [1:0]  res_code_d;
  logic [7:0]  res_rdata_d, sh_val, sh_q;
  logic        sh_load, sh_shift;
  logic [7:0]  cmd_byte;

  // Reset reaches the link domain through its own synchroniser
  vhp_sync2 u_rst_sync (
    .clk   (host_port_clock_pin),
    .rst_n (1'b1),
    .d     (rst_n),
    .q     (lrst_n)
  );
  vhp_sync2 u_req_sync (
    .clk   (host_port_clock_pin),
    .rst_n (lrst_n),
    .d     (tgl_q),
    .q     (req_s)
  );

  assign cmd_byte = {DEVSEL, h_read_q, h_chan_q, h_nib_q};

  vhp_pair_shift #(.W(BYTE_W)) u_shift (
    .clk   (host_port_clock_pin),
    .rst_n (lrst_n),
    .load  (sh_load),
    .val   (sh_val),
    .shift (sh_shift),
    .sin   ({host_ad_line_one_i, host_ad_line_zero_i}),
    .q     (sh_q)
  );

  // Phase sequencer; hold fields are stable while a request is in flight
  always_comb begin
    st_d        = st_q;
    cyc_d       = cyc_q + 2'h1;
    rdy_d       = rdy_q;
    stop_d      = stop_q;
    waits_d     = waits_q;
    ad_oe_d     = ad_oe_q;
    ctl_oe_d    = ctl_oe_q;
    ctl_out_d   = ctl_out_q;
    done_d      = done_tgl_q;
    res_code_d  = res_code_q;
    res_rdata_d = res_rdata_q;
    res_slow_d  = res_slow_q;
    sh_load     = 1'b0;
    sh_val      = cmd_byte;
    sh_shift    = 1'b0;
    fin         = 1'b0;
    unique case (st_q)
      L_IDLE: begin
        cyc_d = 2'h0;
        if (req_s != seen_q) begin
          st_d      = L_CMD;
          sh_load   = 1'b1;
          ad_oe_d   = 1'b1;
          ctl_oe_d  = 1'b1;
          ctl_out_d = 1'b1;
          waits_d   = 3'h0;
        end
      end
      L_CMD, L_ADDR: begin
        sh_shift = 1'b1;
        if (cyc_q == CYC_LAST) begin
          if (st_q == L_CMD && !h_chan_q) begin
            st_d    = L_ADDR;
            sh_load = 1'b1;
            sh_val  = h_addr_q;
          end else begin
            st_d     = L_DEC;
            ctl_oe_d = 1'b0;
            sh_load  = !h_read_q;
            sh_val   = h_wdata_q;
            ad_oe_d  = !h_read_q;
          end
        end
      end
      L_DEC: begin
        st_d   = L_RETRY;
        cyc_d  = 2'h0;
        rdy_d  = 1'b0;
        stop_d = 1'b0;
      end
      L_RETRY, L_WAIT: begin
        if (cyc_q == CYC_READY && !host_control_line_i) begin
          rdy_d = 1'b1;
        end
        if (st_q == L_RETRY && cyc_q == CYC_STOP && !host_control_line_i && !rdy_q) begin
          stop_d = 1'b1;
        end
        if (cyc_q == CYC_LAST) begin
          if (stop_q) begin
            fin        = 1'b1;
            res_code_d = RSP_STOP;
          end else if (rdy_q) begin
            st_d = L_DATA;
          end else begin
            st_d    = L_WAIT;
            rdy_d   = 1'b0;
            waits_d = (waits_q == 3'h7) ? waits_q : waits_q + 3'h1;
          end
        end
      end
      L_DATA: begin
        sh_shift = 1'b1;
        if (cyc_q == CYC_LAST) begin
          fin         = 1'b1;
          res_code_d  = RSP_OK;
          res_rdata_d = {sh_q[5:0], host_ad_line_one_i, host_ad_line_zero_i};
        end
      end
      L_TA: begin
        st_d   = L_IDLE;
        done_d = ~done_tgl_q;
      end
    endcase
    if (fin) begin
      res_slow_d = !h_chan_q && (waits_q > WAIT_OK);
      ad_oe_d    = 1'b0;
      ctl_oe_d   = 1'b0;
      if (h_read_q) begin
        st_d = L_TA;
      end else begin
        st_d   = L_IDLE;
        done_d = ~done_tgl_q;
      end
    end
  end

  always_ff @(posedge host_port_clock_pin) begin
    if (!lrst_n) begin
      st_q        <= L_IDLE;
      seen_q      <= 1'b0;
      cyc_q       <= 2'h0;
      rdy_q       <= 1'b0;
      stop_q      <= 1'b0;
      waits_q     <= 3'h0;
      ad_oe_q     <= 1'b0;
      ctl_oe_q    <= 1'b0;
      ctl_out_q   <= 1'b0;
      done_tgl_q  <= 1'b0;
      res_code_q  <= RSP_OK;
      res_rdata_q <= 8'h00;
      res_slow_q  <= 1'b0;
    end else begin
      st_q        <= st_d;
      seen_q      <= req_s;
      cyc_q       <= cyc_d;
      rdy_q       <= rdy_d;
      stop_q      <= stop_d;
      waits_q     <= waits_d;
      ad_oe_q     <= ad_oe_d;
      ctl_oe_q    <= ctl_oe_d;
      ctl_out_q   <= ctl_out_d;
      done_tgl_q  <= done_d;
      res_code_q  <= res_code_d;
      res_rdata_q <= res_rdata_d;
      res_slow_q  <= res_slow_d;
    end
  end

  // Line one carries the upper bit of each pair
  assign host_ad_line_one_o   = sh_q[7];
  assign host_ad_line_zero_o  = sh_q[6];
  assign host_ad_line_one_oe  = ad_oe_q;
  assign host_ad_line_zero_oe = ad_oe_q;
  assign host_control_line_o  = ctl_out_q;
  assign host_control_line_oe = ctl_oe_q;

  // ---------------- Checks ----------------
  sequence s_wait_entry;
    (st_q == L_RETRY || st_q == L_WAIT) && cyc_q == CYC_LAST && !rdy_q && !stop_q;
  endsequence

  cmd_len_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    (st_q == L_CMD && cyc_q == 2'h0) |-> (st_q == L_CMD)[*4])
    else $error("command phase not four clocks");
  cmd_devsel_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    (st_q == L_CMD && cyc_q == 2'h0) |-> sh_q[7:6] == DEVSEL && ad_oe_q)
    else $error("command byte does not open with device select");
  addr_skip_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    (st_q == L_CMD && cyc_q == CYC_LAST) |=> (st_q == (h_chan_q ? L_DEC : L_ADDR)))
    else $error("address phase presence wrong");
  decode_one_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    st_q == L_DEC |=> st_q == L_RETRY ##3 st_q == L_RETRY && cyc_q == CYC_LAST)
    else $error("decode or retry length wrong");
  stop_end_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    (st_q == L_RETRY && cyc_q == CYC_LAST && stop_q) |=> st_q inside {L_TA, L_IDLE} && !ad_oe_q)
    else $error("stopped transfer did not end");
  wait_next_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    s_wait_entry |=> st_q == L_WAIT && (ad_oe_q == !h_read_q))
    else $error("wait phase missing or bus owner idle");
  data_next_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    ((st_q == L_RETRY || st_q == L_WAIT) && cyc_q == CYC_LAST && rdy_q && !stop_q)
      |=> (st_q == L_DATA)[*4])
    else $error("data phase did not follow ready");
  ta_release_a: assert property (@(posedge host_port_clock_pin) disable iff (!lrst_n)
    st_q == L_TA |-> !ad_oe_q && !ctl_oe_q ##1 st_q == L_IDLE)
    else $error("turnaround wrong");
  // A new request in the answer cycle may legally earn an answer at once
  rsp_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rv_q && !req_valid) |=> !rv_q)
    else $error("answer strobe longer than one cycle");
endmodule

// ===== tb/vhp_dev_model.sv
// Behavioural device answering the host port as a slave
`timescale 1ns/1ps
module vhp_dev_model
  import vhp_pkg::*;
(
  input  wire logic       clk_link,  // Link clock
  input  wire logic       ad0,       // Line zero level
  input  wire logic       ad1,       // Line one level
  input  wire logic [1:0] n_waits,   // Wait phases before ready
  input  wire logic       do_stop,   // Stop in retry
  input  wire logic [7:0] rd_byte,   // Channel and status byte
  output logic      [1:0] ad_o,      // Pair, bit 1 on line one
  output logic            ad_oe,     // Lines driven
  output logic            ctl_oe,    // Control pulled low
  output logic      [7:0] cap_cmd,   // Last command
  output logic      [7:0] cap_addr,  // Last low address
  output logic      [7:0] cap_wdata, // Last write byte
  output int              cap_cnt    // Commands seen
);
  logic [7:0] mem [0:4095];
  logic [7:0] nlr_q;

  // One transfer; samples at the edge, drives 1 ns after it
  task automatic serve();
    logic [7:0] c, a, d, r;
    c = {6'h00, ad1, ad0};
    a = 8'h00;
    d = 8'h00;
    repeat (3) begin
      @(posedge clk_link);
      c = {c[5:0], ad1, ad0};
    end
    if (!c[4]) repeat (4) begin
      @(posedge clk_link);
      a = {a[5:0], ad1, ad0};
    end
    cap_cnt = cap_cnt + 1;
    cap_cmd = c;
    cap_addr = a;
    if (!c[4] && c[3:1] == 3'h0) r = mem[{c[3:0], a}];
    else if (!c[4] && c[3:0] == NIB_NLR2) r = mem[{NIB_GEN, nlr_q}];
    else if (c[4] && c[3:0] == NIB_FST1) r = rd_byte | 8'h03;
    else r = rd_byte;
    #1;
    ad_oe = c[5];
    ad_o = r[7:6];
    @(posedge clk_link);
    #1;
    @(posedge clk_link);
    #1;
    if (do_stop) begin
      @(posedge clk_link);
      #1;
      ctl_oe = 1'b1;
      @(posedge clk_link);
      #1;
      ctl_oe = 1'b0;
      ad_oe = 1'b0;
      // Skip the last retry edge: a write still shows its data pair there
      @(posedge clk_link);
      return;
    end
    // Skipping ready in cycle 1 forces whole wait phases
    repeat (4 * n_waits) @(posedge clk_link);
    #1;
    ctl_oe = 1'b1;
    @(posedge clk_link);
    #1;
    ctl_oe = 1'b0;
    @(posedge clk_link);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_link);
      if (!c[5] && i > 0) d = {d[5:0], ad1, ad0};
      #1;
      if (i < 4) ad_o = 2'(r >> (6 - 2 * i));
      else ad_oe = 1'b0;
    end
    if (!c[5] && !c[4] && c[3:1] == 3'h0) mem[{c[3:0], a}] = d;
    if (c[5] && !c[4] && c[3:0] == NIB_NLR1) nlr_q = a;
    if (!c[5]) cap_wdata = d;
  endtask

  // Lines stay released until a command opens
  initial begin
    ad_o = 2'h0;
    ad_oe = 1'b0;
    ctl_oe = 1'b0;
    cap_cnt = 0;
    cap_cmd = 8'h00;
    cap_addr = 8'h00;
    cap_wdata = 8'h00;
    nlr_q = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    forever begin
      @(posedge clk_link);
      if ({ad1, ad0} === DEVSEL) serve();
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the host port transfer master
`timescale 1ns/1ps
module tb;
  import vhp_pkg::*;
  logic       clk_sys, clk_link, rst_n, req_valid, req_ready, req_read, req_chan;
  logic       rsp_valid, rsp_slow, rsp_d_absent, do_stop, dev_oe, ctl_oe;
  logic       h0_o, h0_oe, h1_o, h1_oe, hc_o, hc_oe;
  logic [3:0] req_space;
  logic [7:0] req_addr, req_wdata, rsp_rdata, cap_cmd, cap_addr, cap_wdata, rd_byte;
  logic [1:0] rsp_code, dev_o, n_waits;
  tri1        ad0, ad1, ctl;
  int         cap_cnt, err_total, checks_done, cyc, seed, nlr;
  int         mem [0:4095];

  // Pulled-up wires; a released party leaves the pull-up level
  assign ad0 = h0_oe ? h0_o : 1'bz;
  assign ad0 = dev_oe ? dev_o[0] : 1'bz;
  assign ad1 = h1_oe ? h1_o : 1'bz;
  assign ad1 = dev_oe ? dev_o[1] : 1'bz;
  assign ctl = hc_oe ? hc_o : 1'bz;
  assign ctl = ctl_oe ? 1'b0 : 1'bz;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Link clock of unrelated phase
  initial begin
    clk_link = 1'b0;
    #3.3;
    forever #7.5 clk_link = ~clk_link;
  end

  vhp_host dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_chan(req_chan),
    .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_rdata(rsp_rdata),
    .rsp_slow(rsp_slow), .rsp_d_absent(rsp_d_absent), .host_port_clock_pin(clk_link),
    .host_ad_line_zero_i(ad0), .host_ad_line_zero_o(h0_o), .host_ad_line_zero_oe(h0_oe),
    .host_ad_line_one_i(ad1), .host_ad_line_one_o(h1_o), .host_ad_line_one_oe(h1_oe),
    .host_control_line_i(ctl), .host_control_line_o(hc_o), .host_control_line_oe(hc_oe));

  vhp_dev_model dev_u (.clk_link(clk_link), .ad0(ad0), .ad1(ad1), .n_waits(n_waits),
    .do_stop(do_stop), .rd_byte(rd_byte), .ad_o(dev_o), .ad_oe(dev_oe), .ctl_oe(ctl_oe),
    .cap_cmd(cap_cmd), .cap_addr(cap_addr), .cap_wdata(cap_wdata), .cap_cnt(cap_cnt));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One request, answer compared with the reference model
  task automatic xfer(input logic rd, input logic ch, input logic [3:0] nib,
                      input logic [7:0] adr, input logic [7:0] wd,
                      input logic [1:0] w, input logic stp);
    int         n;
    int         c0;
    logic       ok;
    logic [7:0] exp;
    ok = !ch ? (nib < 4'h2 || (rd && nib < 4'h4))
             : (rd ? (nib inside {NIB_FST0, NIB_FST1, NIB_CHA, NIB_CHC}) : nib == NIB_CHB);
    // Let an edge pass so the strobe is never lowered and raised in one step
    @(posedge clk_sys);
    #1;
    c0 = cap_cnt;
    n_waits = w;
    do_stop = stp;
    rd_byte = 8'($random(seed));
    req_valid = 1'b1;
    req_read = rd;
    req_chan = ch;
    req_space = nib;
    req_addr = adr;
    req_wdata = wd;
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("answer", 8'h01, {7'h00, rsp_valid});
    exp = {6'h00, !ok ? RSP_BAD : (stp ? RSP_STOP : RSP_OK)};
    chk("code", exp, {6'h00, rsp_code});
    chk("link use", 8'(c0 + 32'(ok)), 8'(cap_cnt));
    if (!ok) begin
      chk("refuse time", 8'h00, 8'(n));
      chk("refuse data", 8'h00, rsp_rdata);
      return;
    end
    chk("command", {DEVSEL, rd, ch, nib}, cap_cmd);
    if (!ch) chk("address", adr, cap_addr);
    if (stp) return;
    if (!rd) chk("write data", wd, cap_wdata);
    chk("slow", {7'h00, !ch && w > 2'h1}, {7'h00, rsp_slow});
    chk("d absent", {7'h00, rd && ch && nib == NIB_FST1}, {7'h00, rsp_d_absent});
    if (ch) exp = (nib == NIB_FST1) ? (rd_byte | 8'h03) : rd_byte;
    else if (nib == NIB_NLR2) exp = 8'(mem[{NIB_GEN, nlr[7:0]}]);
    else exp = 8'(mem[{nib, adr}]);
    if (rd && (ch || nib != NIB_NLR1)) chk("read data", exp, rsp_rdata);
    if (!rd && !ch) mem[{nib, adr}] = 32'(wd);
    if (rd && !ch && nib == NIB_NLR1) nlr = 32'(adr);
  endtask

  // Ceiling well above the expected sweep length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    seed = 76;
    {rst_n, req_valid, req_read, req_chan, do_stop} = 5'h00;
    {req_space, req_addr, req_wdata, rd_byte, n_waits} = 30'h0;
    {err_total, checks_done, cyc, nlr} = 128'h0;
    foreach (mem[i]) mem[i] = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    chk("oe in reset", 8'h00, {5'h00, h0_oe, h1_oe, hc_oe});
    rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("oe idle", 8'h00, {5'h00, h0_oe, h1_oe, hc_oe});
    // Every direction, space and nibble with random waits and stops
    for (int it = 0; it < 8; it++) begin
      for (int k = 0; k < 64; k++) begin
        xfer(k[5], k[4], k[3:0], 8'($random(seed)), 8'($random(seed)),
             2'($unsigned($random(seed)) % 3), ($random(seed) & 7) == 0);
      end
    end
    xfer(1'b0, 1'b0, NIB_GEN, 8'h5A, 8'hC3, 2'h1, 1'b0);
    xfer(1'b1, 1'b0, NIB_NLR1, 8'h5A, 8'h00, 2'h0, 1'b0);
    xfer(1'b1, 1'b0, NIB_NLR2, 8'h00, 8'h00, 2'h0, 1'b0);
    end_sim();
  end
endmodule
